// ### hdl/eeelnp_pkg.sv
// Constants, register map and types for the EEE low-power-idle and next-page block
// ==========================================================================
package eeelnp_pkg;

  // ========================================================================
  // Register map (printed offsets are indices, byte address is four times)
  localparam logic [11:0] EEELNP_IDX_RECOVERY  = 12'h0E6;
  localparam logic [11:0] EEELNP_IDX_BUFLOAD   = 12'h0E7;
  localparam logic [11:0] EEELNP_IDX_NP_TX     = 12'h0E8;
  localparam logic [11:0] EEELNP_IDX_NP_CTRL   = 12'h0E9;
  localparam logic [11:0] EEELNP_IDX_STATUS    = 12'h0EA;
  localparam int          EEELNP_ADDR_W        = 14;

  // ========================================================================
  // Reset values and fields
  localparam logic [7:0]  EEELNP_RECOVERY_RST  = 8'h27;
  localparam int          EEELNP_TRAFFIC_EN_B  = 7;
  localparam logic [5:0]  EEELNP_THRESH_RST    = 6'h08;
  localparam logic [10:0] EEELNP_CODE_RST      = 11'h001;
  localparam int          EEELNP_NP_B          = 15;
  localparam int          EEELNP_MP_B          = 13;
  localparam int          EEELNP_CAN_COMPLY_FLAG_B        = 12;
  localparam int          EEELNP_TOG_B         = 11;
  localparam int          EEELNP_BUF_UNIT_SH   = 9;

  // ========================================================================
  // Timing
  localparam int          EEELNP_CLK_HZ        = 20_000_000;
  localparam int          EEELNP_TICK_NS       = 640;
  localparam int          EEELNP_TICK_CYC      = (EEELNP_TICK_NS * (EEELNP_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [4:0]  EEELNP_TICK_LAST     = 5'(EEELNP_TICK_CYC - 1);

  typedef enum logic [1:0] {
    EEELNP_ST_IDLE = 2'b00,
    EEELNP_ST_LPI  = 2'b01,
    EEELNP_ST_WAIT = 2'b11
  } eeelnp_state_t;

endpackage

// ### hdl/eeelnp_tick_if.sv
// Interface carrying the 640 ns tick between the top and the timer
interface eeelnp_tick_if;
  logic tick;
  logic clr;
  modport gen (output tick, input clr);
  modport use_ (input tick, output clr);
endinterface

// ### hdl/eeelnp_tick_gen.sv
// 640 ns tick generator, restarted by the clear from the top
module eeelnp_tick_gen
  import eeelnp_pkg::*;
(
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  // Tick
  eeelnp_tick_if.gen        tk
);
  logic [4:0] cnt_r;
  logic       tick_r;
  wire        wrap = (cnt_r == EEELNP_TICK_LAST);

  // Restart on clear so the first tick of a wait is a full period
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r  <= 5'h00;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= (tk.clr || wrap) ? 5'h00 : cnt_r + 5'h01;
      tick_r <= wrap && !tk.clr;
    end
  end
  assign tk.tick = tick_r;
endmodule

// ### hdl/eeelnp_top.sv
// Top: APB register bank, LPI recovery timer, LPI termination and next-page word
//
// Decided for this implementation: the APB slave port.
module eeelnp_top
  import eeelnp_pkg::*;
#(
  parameter int BUF_W = 16
) (
  // Clock and reset
  input  wire logic                       mclk_i,
  input  wire logic                       rst_n_i,
  // APB slave
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [EEELNP_ADDR_W-1:0]   paddr_i,
  input  wire logic [31:0]                pwdata_i,
  input  wire logic [3:0]                 pstrb_i,
  output logic      [31:0]                prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  // MAC low-power idle
  input  wire logic                       lpi_req_i,
  input  wire logic                       input_traffic_i,
  input  wire logic [BUF_W-1:0]           src_buf_bytes_i,
  output logic                            lpi_req_o,
  output logic                            lpi_terminate_o,
  output logic                            tx_hold_o,
  // Next-page exchange with the negotiation engine
  input  wire logic                       base_toggle_i,
  input  wire logic                       page_sent_i,
  input  wire logic                       np_start_i,
  input  wire logic                       np_eee_agreed_i,
  output logic      [15:0]                np_tx_word_o,
  output logic                            eee_enabled_o
);
  import eeelnp_pkg::*;

  // ========================================================================
  // Registers
  logic [7:0]    recovery_r;
  logic          traffic_en_r;
  logic [5:0]    thresh_r;
  logic          more_pages_follow_r;
  logic          message_page_flag_r;
  logic          can_comply_flag_r;
  logic [10:0]   code_r;
  logic          toggle_r;
  logic          eee_en_r;
  logic [7:0]    wait_cnt_r;
  eeelnp_state_t state_r;
  eeelnp_state_t state_nxt;
  logic          req_r;
  logic          term_r;
  logic          hold_r;
  logic [31:0]   rdata_r;
  logic          ready_r;
  logic          err_r;
  logic [15:0]   np_word_r;

  eeelnp_tick_if tk ();
  eeelnp_tick_gen u_tick (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .tk      (tk.gen)
  );

  // ========================================================================
  // APB decode; answers in the access cycle, zero wait states
  wire        word_ok   = (paddr_i[1:0] == 2'b00);
  wire [11:0] idx       = paddr_i[EEELNP_ADDR_W-1:2];
  wire        sel_rec   = word_ok && idx == EEELNP_IDX_RECOVERY;
  wire        sel_buf   = word_ok && idx == EEELNP_IDX_BUFLOAD;
  wire        sel_np    = word_ok && idx == EEELNP_IDX_NP_TX;
  wire        sel_npc   = word_ok && idx == EEELNP_IDX_NP_CTRL;
  wire        sel_sts   = word_ok && idx == EEELNP_IDX_STATUS;
  wire        mapped    = sel_rec | sel_buf | sel_np | sel_npc | sel_sts;
  wire        setup     = psel_i && !penable_i;
  wire        acc       = psel_i && penable_i && ready_r;
  wire        wr        = acc && pwrite_i && mapped;
  wire        wr_b0     = wr && pstrb_i[0];
  wire        wr_b1     = wr && pstrb_i[1];

  // Control word view: np[0], mp[1], can_comply_flag[2]; code in np_tx word
  wire [15:0] np_word   = {more_pages_follow_r, 1'b0, message_page_flag_r,
                           can_comply_flag_r, toggle_r, code_r};
  wire [31:0] rd_mux    =
      sel_rec ? {24'h000000, recovery_r} :
      sel_buf ? {24'h000000, traffic_en_r, 1'b0, thresh_r} :
      sel_np  ? {16'h0000, np_word} :
      sel_npc ? {29'h00000000, can_comply_flag_r, message_page_flag_r, more_pages_follow_r} :
      sel_sts ? {22'h000000, 2'(state_r), wait_cnt_r} | {31'h00000000, 1'b0} |
                {16'h0000, eee_en_r, 15'h0000} :
      32'h00000000;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_r <= 1'b0;
      rdata_r <= 32'h00000000;
      err_r   <= 1'b0;
    end else begin
      ready_r <= setup;
      rdata_r <= setup ? rd_mux : 32'h00000000;
      err_r   <= setup && !mapped;
    end
  end

  // ========================================================================
  // Software-written fields
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      recovery_r          <= EEELNP_RECOVERY_RST;
      traffic_en_r        <= 1'b0;
      thresh_r            <= EEELNP_THRESH_RST;
      more_pages_follow_r <= 1'b0;
      message_page_flag_r <= 1'b1;
      can_comply_flag_r   <= 1'b0;
      code_r              <= EEELNP_CODE_RST;
    end else begin
      if (wr_b0 && sel_rec) begin
        recovery_r <= pwdata_i[7:0];
      end
      if (wr_b0 && sel_buf) begin
        traffic_en_r <= pwdata_i[EEELNP_TRAFFIC_EN_B];
        thresh_r     <= pwdata_i[5:0];
      end
      if (wr_b0 && sel_npc) begin
        more_pages_follow_r <= pwdata_i[0];
        message_page_flag_r <= pwdata_i[1];
        can_comply_flag_r   <= pwdata_i[2];
      end
      if (sel_np && wr_b0) begin
        code_r[7:0] <= pwdata_i[7:0];
      end
      if (sel_np && wr_b1) begin
        code_r[10:8] <= pwdata_i[10:8];
      end
    end
  end

  // ========================================================================
  // Toggle and hardware EEE enable from the next-page exchange
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      toggle_r <= 1'b0;
      eee_en_r <= 1'b0;
    end else begin
      if (np_start_i) begin
        toggle_r <= !base_toggle_i;
      end else if (page_sent_i) begin
        toggle_r <= !toggle_r;
      end
      if (np_start_i) begin
        eee_en_r <= 1'b0;
      end else if (page_sent_i && !more_pages_follow_r) begin
        eee_en_r <= np_eee_agreed_i;
      end
    end
  end

  // ========================================================================
  // Low-power idle request, termination and recovery wait
  // Buffer usage compared in 512-byte units; a partial unit counts as over
  wire [BUF_W-1:0] thresh_bytes = BUF_W'({thresh_r, 9'h000});
  wire             buf_over     = src_buf_bytes_i > thresh_bytes;
  wire             traffic_kill = traffic_en_r && input_traffic_i;
  wire             kill         = buf_over || traffic_kill;
  wire             wait_done    = (wait_cnt_r == 8'h00);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      EEELNP_ST_IDLE: if (lpi_req_i && !kill) begin
        state_nxt = EEELNP_ST_LPI;
      end
      EEELNP_ST_LPI: if (!lpi_req_i || kill) begin
        state_nxt = EEELNP_ST_WAIT;
      end
      EEELNP_ST_WAIT: if (wait_done || (tk.tick && wait_cnt_r == 8'h01)) begin
        state_nxt = EEELNP_ST_IDLE;
      end
      default: state_nxt = EEELNP_ST_IDLE;
    endcase
  end

  assign tk.clr = (state_r == EEELNP_ST_LPI) && (state_nxt == EEELNP_ST_WAIT);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r    <= EEELNP_ST_IDLE;
      wait_cnt_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (tk.clr) begin
        wait_cnt_r <= recovery_r;
      end else if (state_r == EEELNP_ST_WAIT && tk.tick && !wait_done) begin
        wait_cnt_r <= wait_cnt_r - 8'h01;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_r     <= 1'b0;
      term_r    <= 1'b0;
      hold_r    <= 1'b0;
      np_word_r <= {2'b00, 1'b1, 2'b00, EEELNP_CODE_RST};
    end else begin
      req_r     <= (state_nxt == EEELNP_ST_LPI);
      term_r    <= (state_r == EEELNP_ST_LPI) && kill;
      hold_r    <= (state_nxt == EEELNP_ST_WAIT);
      np_word_r <= np_word;
    end
  end

  // ========================================================================
  // Outputs
  assign prdata_o        = rdata_r;
  assign pready_o        = ready_r;
  assign pslverr_o       = err_r;
  assign lpi_req_o       = req_r;
  assign lpi_terminate_o = term_r;
  assign tx_hold_o       = hold_r;
  assign np_tx_word_o    = np_word_r;
  assign eee_enabled_o   = eee_en_r;
endmodule

// ### verification/eeelnp_top_assertions.sv
// Checker for the APB, LPI and next-page behaviour at the top ports
module eeelnp_top_assertions
  import eeelnp_pkg::*;
#(
  parameter int BUF_W = 16
) (
  // Clock, reset and APB
  input wire logic                     mclk_i,
  input wire logic                     rst_n_i,
  input wire logic                     psel_i,
  input wire logic                     penable_i,
  input wire logic [EEELNP_ADDR_W-1:0] paddr_i,
  input wire logic [31:0]              prdata_o,
  input wire logic                     pready_o,
  input wire logic                     pslverr_o,
  // LPI and next page
  input wire logic                     lpi_req_i,
  input wire logic                     lpi_req_o,
  input wire logic                     lpi_terminate_o,
  input wire logic                     tx_hold_o,
  input wire logic                     base_toggle_i,
  input wire logic                     page_sent_i,
  input wire logic                     np_start_i,
  input wire logic [15:0]              np_tx_word_o,
  input wire logic                     eee_enabled_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o) else $error("pready late");
  a_ready_one_cycle: assert property (pready_o |=> !pready_o) else $error("pready stuck");
  a_err_misaligned: assert property (psel_i && !penable_i && paddr_i[1:0] != 2'h0 |=> pslverr_o)
    else $error("misaligned not refused");
  a_rdata_idle_zero: assert property (!pready_o |-> prdata_o == 32'h0) else $error("prdata not zero");
  a_np_reserved_bit: assert property (np_tx_word_o[14] == 1'b0) else $error("bit 14 set");
  a_hold_after_lpi: assert property ($fell(lpi_req_o) |-> ##[0:2] tx_hold_o) else $error("no hold");
  a_kill_gives_hold: assert property (lpi_terminate_o |-> ##[0:2] tx_hold_o) else $error("no hold");
  // Request output is registered from the next state, so it drops on the first edge and one cycle is enough
  a_req_drop_ends: assert property (!lpi_req_i |=> !lpi_req_o) else $error("request stays");
  a_start_toggle: assert property (np_start_i |-> ##2 np_tx_word_o[11] == !$past(base_toggle_i, 2))
    else $error("first toggle wrong");
  a_page_toggles: assert property (page_sent_i && !np_start_i |-> ##2
    np_tx_word_o[11] != $past(np_tx_word_o[11], 2)) else $error("toggle kept");
  a_start_clears_eee: assert property (np_start_i |=> !eee_enabled_o) else $error("eee kept");
endmodule
bind eeelnp_top eeelnp_top_assertions #(.BUF_W(BUF_W)) i_eeelnp_top_assertions (.mclk_i, .rst_n_i,
  .psel_i, .penable_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .lpi_req_i, .lpi_req_o,
  .lpi_terminate_o, .tx_hold_o, .base_toggle_i, .page_sent_i, .np_start_i, .np_tx_word_o, .eee_enabled_o);

// ### verification/eeelnp_partner.sv
// Link partner model driving the next-page exchange events
module eeelnp_partner (
  // Clock
  input  wire logic mclk_i,
  // Exchange events
  output logic      base_toggle_o,
  output logic      np_start_o,
  output logic      page_sent_o,
  output logic      agreed_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {base_toggle_o, np_start_o, page_sent_o, agreed_o} = 4'h0;
  end
  // Base word toggle stays put for the whole exchange
  task start(input logic t);
    @(posedge mclk_i);
    base_toggle_o <= t;
    np_start_o    <= 1'b1;
    @(posedge mclk_i);
    np_start_o <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask
  task page(input logic ag);
    @(posedge mclk_i);
    agreed_o    <= ag;
    page_sent_o <= 1'b1;
    @(posedge mclk_i);
    page_sent_o <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask
endmodule

// ### verification/eeelnp_top_tb.sv
// Self-checking testbench for the EEE LPI and next-page block
module eeelnp_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import eeelnp_pkg::*;
  logic mclk_i = 0, rst_n_i = 0, psel = 0, pen = 0, pwr = 0, lreq = 0, traf = 0, e;
  logic [13:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [15:0] sbuf = 0, npw;
  logic prdy, perr, lpi_o, term, hold, btog, psent, nps, agr, eee, b;
  int bad_count = 0, comparisons = 0, cyc = 0, n, x;
  int rec = 39, thr = 8, ten = 0, code = 1, more = 0, mp = 1, can_comply_flag = 0, tog = 0;
  logic [11:0] idx [4] = '{EEELNP_IDX_RECOVERY, EEELNP_IDX_BUFLOAD, EEELNP_IDX_NP_TX, EEELNP_IDX_NP_CTRL};
  int kt [4][4] = '{'{0, 1, 0, 1}, '{1, 1, 0, 0}, '{0, 0, 1024, 1}, '{0, 0, 1025, 0}};
  int rv [3] = '{0, 3, 1};
  eeelnp_top i_eeelnp_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata),
    .pready_o(prdy), .pslverr_o(perr), .lpi_req_i(lreq), .input_traffic_i(traf), .src_buf_bytes_i(sbuf),
    .lpi_req_o(lpi_o), .lpi_terminate_o(term), .tx_hold_o(hold), .base_toggle_i(btog),
    .page_sent_i(psent), .np_start_i(nps), .np_eee_agreed_i(agr), .np_tx_word_o(npw), .eee_enabled_o(eee));
  eeelnp_partner i_eeelnp_partner (.mclk_i(mclk_i), .base_toggle_o(btog), .np_start_o(nps),
    .page_sent_o(psent), .agreed_o(agr));
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  function automatic logic [13:0] ba(logic [11:0] i);
    return {i, 2'b00};
  endfunction
  function automatic logic [31:0] ex(logic [11:0] i);
    case (i)
      EEELNP_IDX_RECOVERY: return rec;
      EEELNP_IDX_BUFLOAD:  return ten * 128 + thr;
      EEELNP_IDX_NP_TX:    return more * 32768 + mp * 8192 + can_comply_flag * 4096 + tog * 2048 + code;
      EEELNP_IDX_NP_CTRL:  return more + mp * 2 + can_comply_flag * 4;
      default:             return 0;
    endcase
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] w);
    comparisons++;
    if (g !== w) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, w);
    end
  endtask
  task apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk_i);
    psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge mclk_i);
    pen <= 1;
    k = 0;
    do begin @(posedge mclk_i); k++; end while (prdy !== 1'b1);
    r = prdata; e = perr; psel <= 0; pen <= 0;
  endtask
  task wr(input logic [11:0] i, input logic [31:0] d);
    apb(1, ba(i), d);
    case (i)
      EEELNP_IDX_RECOVERY: rec = d[7:0];
      EEELNP_IDX_BUFLOAD:  begin ten = d[7]; thr = d[5:0]; end
      EEELNP_IDX_NP_TX:    code = d[10:0];
      default:             begin more = d[0]; mp = d[1]; can_comply_flag = d[2]; end
    endcase
  endtask
  task rdc(input logic [11:0] i);
    apb(0, ba(i), 0);
    chk(r, ex(i));
    chk(e, 0);
  endtask
  task complete_run;
    $display("Counts: %0d mismatches in %0d comparisons", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin bad_count++; complete_run; end
  end
  initial begin
    void'($urandom(78299));
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1;
    foreach (idx[j]) rdc(idx[j]);
    apb(0, ba(EEELNP_IDX_STATUS) + 14'h8, 0);
    chk(e, 1); chk(r, 0);
    apb(1, ba(EEELNP_IDX_RECOVERY) + 14'h1, 5);
    chk(e, 1); rdc(EEELNP_IDX_RECOVERY);
    $display("Test reset and map done");
    repeat (4) foreach (idx[j]) begin wr(idx[j], $urandom); rdc(idx[j]); end
    $display("Test random access done");
    foreach (rv[j]) begin
      wr(EEELNP_IDX_RECOVERY, rv[j]);
      lreq <= 1; repeat (4) @(posedge mclk_i);
      chk(lpi_o, 1); lreq <= 0; n = 0;
      while (hold !== 1'b1 && n < 10) begin @(posedge mclk_i); n++; end
      n = 0;
      while (hold === 1'b1 && n < 100) begin n++; @(posedge mclk_i); end
      // Hold spans the load cycle plus one full tick period per count
      x = rv[j] * EEELNP_TICK_CYC + 1;
      chk(n, x);
    end
    $display("Test recovery wait done");
    foreach (kt[j]) begin
      wr(EEELNP_IDX_BUFLOAD, kt[j][0] * 128 + 2);
      traf <= kt[j][1]; sbuf <= kt[j][2]; lreq <= 1;
      repeat (20) @(posedge mclk_i);
      chk(lpi_o, kt[j][3]);
      traf <= 0; sbuf <= 0; lreq <= 0;
      repeat (60) @(posedge mclk_i);
    end
    // Traffic arriving while already idle must cut the request short
    wr(EEELNP_IDX_BUFLOAD, 128 + 2);
    lreq <= 1;
    repeat (4) @(posedge mclk_i);
    traf <= 1;
    repeat (2) @(posedge mclk_i);
    chk(term, 1);
    chk(hold, 1);
    traf <= 0; lreq <= 0;
    repeat (60) @(posedge mclk_i);
    chk(term, 0);
    $display("Test termination done");
    b = $urandom;
    i_eeelnp_partner.start(b); tog = !b;
    rdc(EEELNP_IDX_NP_TX);
    wr(EEELNP_IDX_NP_CTRL, 1);
    i_eeelnp_partner.page(1); tog = !tog;
    chk(eee, 0); rdc(EEELNP_IDX_NP_TX);
    wr(EEELNP_IDX_NP_CTRL, 0);
    i_eeelnp_partner.page(1); tog = !tog;
    chk(eee, 1); rdc(EEELNP_IDX_NP_TX);
    apb(0, ba(EEELNP_IDX_STATUS), 0);
    chk(r[15], 1);
    i_eeelnp_partner.start(!b); tog = b;
    chk(eee, 0); rdc(EEELNP_IDX_NP_TX);
    $display("Test next page done");
    complete_run;
  end
endmodule
